// ---- common/e1fs_pkg.sv ----
// shared constants and types of the receive frame synchroniser
package e1fs_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] E1FS_OFS_CTRL = 4'h0;
  localparam logic [3:0] E1FS_OFS_STATUS = 4'h1;
  localparam logic [3:0] E1FS_OFS_IND = 4'h2;
  localparam logic [3:0] E1FS_OFS_EN = 4'h3;
  localparam logic [3:0] E1FS_OFS_INTL = 4'h4;
  localparam logic [3:0] E1FS_OFS_NAT = 4'h5;
  localparam logic [3:0] E1FS_OFS_CRC = 4'h6;
  localparam logic [3:0] E1FS_OFS_EXTRA = 4'h7;
  localparam logic [3:0] E1FS_OFS_SA4 = 4'h8;
  localparam logic [3:0] E1FS_OFS_SA8 = 4'hC;

  // ****************************************************************
  // control field positions and reset value
  // ****************************************************************
  localparam int E1FS_CTL_UNFRAMED = 0;
  localparam int E1FS_CTL_CRC_EN = 1;
  localparam int E1FS_CTL_CAS_EN = 2;
  localparam int E1FS_CTL_CONT = 3;
  localparam int E1FS_CTL_REFRAME = 4;
  localparam int E1FS_CTL_DEB4 = 5;
  localparam int E1FS_CTL_SRST = 6;
  localparam logic [7:0] E1FS_CTRL_RST = 8'h00;
  localparam logic [7:0] E1FS_CTRL_MASK = 8'h3F;
  localparam logic [7:0] E1FS_EN_RST = 8'h00;

  // ****************************************************************
  // interrupt indication positions
  // ****************************************************************
  localparam int E1FS_IRQ_OOF = 0;
  localparam int E1FS_IRQ_OOCMF = 1;
  localparam int E1FS_IRQ_OOSMF = 2;
  localparam int E1FS_IRQ_CMFERR = 3;
  localparam int E1FS_IRQ_FRAME = 4;
  localparam int E1FS_IRQ_SMF = 5;
  localparam int E1FS_IRQ_MF = 6;
  localparam int E1FS_IRQ_CASMF = 7;

  // ****************************************************************
  // frame structure
  // ****************************************************************
  localparam logic [7:0] E1FS_TS0_END = 8'h07;
  localparam logic [7:0] E1FS_TS16_END = 8'h87;
  localparam logic [4:0] E1FS_TS16 = 5'h10;
  localparam logic [6:0] E1FS_FAS_WORD = 7'h1B;
  localparam logic [5:0] E1FS_CRC_MFAS = 6'h0B;
  localparam logic [3:0] E1FS_MF_SMF1_END = 4'h7;
  localparam logic [3:0] E1FS_MF_ALIGN = 4'hB;
  localparam logic [3:0] E1FS_MF_AFTER_ALIGN = 4'hC;
  localparam logic [3:0] E1FS_MF_E1 = 4'hD;
  localparam logic [3:0] E1FS_MF_LAST = 4'hF;
  localparam logic [1:0] E1FS_FAS_LOSS = 2'h2;
  localparam logic [8:0] E1FS_AIS_WIN_END = 9'h1FF;
  localparam logic [1:0] E1FS_AIS_ZEROS = 2'h3;
  localparam logic [6:0] E1FS_SPACE_MAX = 7'h7F;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned E1FS_CLK_KHZ = 250000;
  localparam int unsigned E1FS_T_CRC8_MS = 8;
  localparam int unsigned E1FS_T_CRC400_MS = 400;
  localparam int unsigned E1FS_T_RED_MS = 100;
  localparam int unsigned E1FS_CRC8_CYC = E1FS_T_CRC8_MS * E1FS_CLK_KHZ;
  localparam int unsigned E1FS_CRC400_CYC = E1FS_T_CRC400_MS * E1FS_CLK_KHZ;
  localparam int unsigned E1FS_RED_CYC = E1FS_T_RED_MS * E1FS_CLK_KHZ;

  // ****************************************************************
  // basic frame search states
  // ****************************************************************
  typedef enum logic [2:0] {
    E1FS_HUNT = 3'b000,
    E1FS_CHK_NFAS = 3'b001,
    E1FS_SKIP = 3'b010,
    E1FS_CHK_FAS2 = 3'b011,
    E1FS_SYNC = 3'b100
  } e1fs_frm_t;

endpackage

// ---- src/e1fs_debounce.sv ----
// persistence filter for one received alarm bit
module e1fs_debounce
  import e1fs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sample,
  input wire logic value,
  input wire logic need_four,
  output logic filtered
);

  typedef struct packed {
    logic last;
    logic [1:0] run;
    logic filt;
  } e1fs_deb_t;

  e1fs_deb_t q;
  e1fs_deb_t n;

  always_comb begin
    n = q;
    if (sample) begin
      n.last = value;
      if (value == q.last) begin
        n.run = (q.run == 2'h3) ? 2'h3 : 2'(q.run + 2'h1);
      end else begin
        n.run = 2'h0;
      end
      // run counts repeats after the first sample, so 0 means one occurrence
      if (!need_four || n.run == 2'h3) begin
        n.filt = value;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign filtered = q.filt;

endmodule

// ---- src/e1fs_top.sv ----
// receive frame synchroniser: basic, crc and signaling multiframe alignment
//
// Overview of operation
// [R1] A software reset restarts the basic frame search.
// [R2] Timeslot 16 bits are driven onto their own output pin.
// [R3] International, national and signaling frame-zero extra bits are held in registers.
// [R4] Each Sa4..Sa8 four-bit codeword is stored once per sub multiframe.
// [R5] Remote alarm from TS0 bit 3 of NFAS; multiframe alarm from TS16 bit 6.
// [R6] Both alarms are filtered over 1 or 4 equal consecutive samples.
// [R7] AIS is detected; red alarm after 100 ms of continuous out of frame.
// [R8] Interrupt output for status changes and frame-structure boundary events.
// [R9] Unframed mode passes data on and does no frame processing.
// [R10] Frame found by FAS, NFAS, FAS; step two fail skips a frame.
// [R11] Out-of-frame status goes to 0 when basic alignment is found.
// [R12] CRC multiframe is 16 frames from a FAS frame, two halves of eight.
// [R13] Si of even frames are CRC bits, four per half, first is MSB.
// [R14] Si of first six odd frames must carry 001011.
// [R15] Si of frames 13 and 15 are the two far end block error bits.
// [R16] With CRC search enabled, 8 ms and 400 ms timers start after alignment.
// [R17] CRC alignment needs two patterns within 8 ms spaced by multiples of 2 ms.
// [R18] Once CRC aligned, a wrong alignment pattern sets an error flag.
// [R19] Failing 8 ms starts an offline search, flagged, retried until 400 ms.
// [R20] 400 ms expiry while framed flags interworking; search goes on if continue set.
// [R21] Signaling multiframe search starts after alignment only when enabled.
// [R22] TS16 nibble 0000 after a nonzero nibble marks signaling frame zero.
// [R23] Frame-zero TS16 reads 0000XYXX: Y remote alarm, X extra bits.
// [R24] FAS is 0011011 in bits 2..8; NFAS needs bit 2 at 1.
// [R25] A 0-to-1 write on the manual reframe bit restarts basic search.
// [R26] Indication bits set on change or event, cleared by writing 1, gated by enable.
//
// Local design decisions: the register addresses and the strobed register port.
module e1fs_top
  import e1fs_pkg::*;
#(
  parameter int unsigned CRC8_CYCLES = E1FS_CRC8_CYC,
  parameter int unsigned CRC400_CYCLES = E1FS_CRC400_CYC,
  parameter int unsigned RED_CYCLES = E1FS_RED_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rx_line_data,
  input wire logic rx_line_clk,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic ts16_data,
  output logic ts16_valid,
  output logic bypass_data,
  output logic bypass_valid
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] data_sync;
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [7:0] sh;
    logic [7:0] cnt;
    e1fs_frm_t frm;
    logic fas_exp;
    logic [1:0] fas_err;
    logic [5:0] si6;
    logic [6:0] fr_since;
    logic have_prev;
    logic crc_al;
    logic [3:0] mf_num;
    logic [31:0] t8;
    logic [31:0] t400;
    logic offline;
    logic iw;
    logic [3:0] crc_sh;
    logic [3:0] crc_bits;
    logic [19:0] sa_sh;
    logic [19:0] sa_cw;
    logic e_bit1;
    logic e_bit2;
    logic cas_al;
    logic [3:0] cas_num;
    logic [3:0] prev_nib;
    logic [2:0] extra;
    logic si_fas;
    logic si_nfas;
    logic a_bit;
    logic [4:0] sa_bits;
    logic [8:0] ais_cnt;
    logic [1:0] zeros;
    logic ais;
    logic [31:0] red_cnt;
    logic red;
    logic [7:0] ctrl;
    logic [7:0] ind;
    logic [7:0] en;
    logic [7:0] rd_data;
    logic irq;
    logic ts16_data;
    logic ts16_valid;
    logic byp_data;
    logic byp_valid;
  } e1fs_state_t;

  e1fs_state_t q;
  e1fs_state_t n;

  logic rai_filt;
  logic rmf_filt;
  logic rai_smp;
  logic rai_val;
  logic rmf_smp;
  logic rmf_val;
  logic rising;
  logic rx_bit;
  logic [7:0] nsh;
  logic [7:0] ev;
  logic [7:0] clr;
  logic reframe;
  logic crc_search;
  logic [6:0] fs_inc;
  logic [1:0] zn;
  logic [7:0] rd_val;

  // ****************************************************************
  // alarm persistence filters
  // ****************************************************************
  // [R6] filtered remote alarm
  e1fs_debounce u_rai_deb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sample(rai_smp),
    .value(rai_val),
    .need_four(q.ctrl[E1FS_CTL_DEB4]),
    .filtered(rai_filt)
  );

  // [R6] filtered multiframe alarm
  e1fs_debounce u_rmf_deb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sample(rmf_smp),
    .value(rmf_val),
    .need_four(q.ctrl[E1FS_CTL_DEB4]),
    .filtered(rmf_filt)
  );

  // ****************************************************************
  // register read mux
  // ****************************************************************
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      E1FS_OFS_CTRL: rd_val = q.ctrl;
      E1FS_OFS_STATUS: rd_val = {rai_filt, q.red, q.ais, q.iw, q.offline, ~q.cas_al,
                                 ~q.crc_al, q.frm != E1FS_SYNC};
      E1FS_OFS_IND: rd_val = q.ind;
      E1FS_OFS_EN: rd_val = q.en;
      E1FS_OFS_INTL: rd_val = {5'h00, q.a_bit, q.si_nfas, q.si_fas};
      E1FS_OFS_NAT: rd_val = {3'h0, q.sa_bits};
      E1FS_OFS_CRC: rd_val = {1'b0, rmf_filt, q.e_bit2, q.e_bit1, q.crc_bits};
      E1FS_OFS_EXTRA: rd_val = {5'h00, q.extra};
      default: begin
        if (reg_addr >= E1FS_OFS_SA4 && reg_addr <= E1FS_OFS_SA8) begin
          rd_val = {4'h0, q.sa_cw[19 - 4 * (reg_addr - E1FS_OFS_SA4) -: 4]};
        end
      end
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = q;
    ev = 8'h00;
    clr = 8'h00;
    reframe = 1'b0;
    rai_smp = 1'b0;
    rai_val = 1'b0;
    rmf_smp = 1'b0;
    rmf_val = 1'b0;
    rising = q.clk_sync[1] & ~q.clk_prev;
    rx_bit = q.data_sync[1];
    nsh = {q.sh[6:0], rx_bit};
    fs_inc = (q.fr_since == E1FS_SPACE_MAX) ? q.fr_since : 7'(q.fr_since + 7'h01);
    zn = (rx_bit || q.zeros == E1FS_AIS_ZEROS) ? q.zeros : 2'(q.zeros + 2'h1);
    // [R20] once interworking is declared, searching goes on only with continue set
    crc_search = q.frm == E1FS_SYNC && q.ctrl[E1FS_CTL_CRC_EN] && !q.crc_al
                 && !(q.iw && !q.ctrl[E1FS_CTL_CONT]);

    n.data_sync = {q.data_sync[0], rx_line_data};
    n.clk_sync = {q.clk_sync[0], rx_line_clk};
    n.clk_prev = q.clk_sync[1];
    n.ts16_valid = 1'b0;
    n.byp_valid = 1'b0;
    n.rd_data = reg_rd ? rd_val : 8'h00;

    if (reg_wr) begin
      case (reg_addr)
        E1FS_OFS_CTRL: begin
          n.ctrl = reg_wdata & E1FS_CTRL_MASK;
          // [R25] reframe on a rising edge; [R1] software reset pulse
          reframe = (reg_wdata[E1FS_CTL_REFRAME] & ~q.ctrl[E1FS_CTL_REFRAME])
                    | reg_wdata[E1FS_CTL_SRST];
        end
        E1FS_OFS_IND: clr = reg_wdata;
        E1FS_OFS_EN: n.en = reg_wdata;
        default: ;
      endcase
    end

    if (rising) begin
      n.sh = nsh;
      n.cnt = 8'(q.cnt + 8'h01);
      // [R9] raw data always leaves on the bypass pin
      n.byp_data = rx_bit;
      n.byp_valid = 1'b1;

      // [R7] ais: fewer than three zeros in two frames of bits
      n.ais_cnt = 9'(q.ais_cnt + 9'h001);
      n.zeros = zn;
      if (q.ais_cnt == E1FS_AIS_WIN_END) begin
        n.ais = zn != E1FS_AIS_ZEROS;
        n.zeros = 2'h0;
      end

      case (q.frm)
        E1FS_HUNT: begin
          // [R24] alignment word seen at any bit position
          if (nsh[6:0] == E1FS_FAS_WORD) begin
            n.cnt = E1FS_TS0_END + 8'h01;
            n.frm = E1FS_CHK_NFAS;
          end
        end
        E1FS_CHK_NFAS: begin
          // [R10] step two fail skips a frame
          if (q.cnt == E1FS_TS0_END) begin
            n.frm = nsh[6] ? E1FS_CHK_FAS2 : E1FS_SKIP;
          end
        end
        E1FS_SKIP: begin
          if (q.cnt == E1FS_TS0_END) begin
            n.frm = E1FS_HUNT;
          end
        end
        E1FS_CHK_FAS2: begin
          // [R10] step three fail hunts again at once
          if (q.cnt == E1FS_TS0_END) begin
            n.frm = (nsh[6:0] == E1FS_FAS_WORD) ? E1FS_SYNC : E1FS_HUNT;
            n.fas_exp = 1'b0;
            n.fas_err = 2'h0;
          end
        end
        E1FS_SYNC: begin
          // [R2] timeslot 16 stream out
          if (q.cnt[7:3] == E1FS_TS16) begin
            n.ts16_data = rx_bit;
            n.ts16_valid = 1'b1;
          end
          if (q.cnt == E1FS_TS0_END) begin
            n.fas_exp = ~q.fas_exp;
            n.fr_since = fs_inc;
            ev[E1FS_IRQ_FRAME] = 1'b1;
            if (q.crc_al) begin
              n.mf_num = 4'(q.mf_num + 4'h1);
            end
            if (q.fas_exp) begin
              // [R24] three bad alignment words in a row drop the frame
              if (nsh[6:0] != E1FS_FAS_WORD) begin
                n.fas_err = 2'(q.fas_err + 2'h1);
                if (q.fas_err == E1FS_FAS_LOSS) begin
                  n.frm = E1FS_HUNT;
                end
              end else begin
                n.fas_err = 2'h0;
              end
              // [R3] Si of the alignment frame
              n.si_fas = nsh[7];
              // [R13] CRC bit, first one ends up most significant
              n.crc_sh = {q.crc_sh[2:0], nsh[7]};
            end else begin
              // [R3] [R5] international, alarm and national bits
              n.si_nfas = nsh[7];
              n.a_bit = nsh[5];
              n.sa_bits = nsh[4:0];
              rai_smp = 1'b1;
              rai_val = nsh[5];
              n.si6 = {q.si6[4:0], nsh[7]};
              // [R4] one bit into each national codeword
              for (int k = 0; k < 5; k++) begin
                n.sa_sh[19 - 4 * k -: 4] = {q.sa_sh[18 - 4 * k -: 3], nsh[4 - k]};
              end
              if (q.crc_al) begin
                // [R12] halves end at frames 7 and 15
                if (q.mf_num == E1FS_MF_SMF1_END || q.mf_num == E1FS_MF_LAST) begin
                  n.crc_bits = q.crc_sh;
                  n.sa_cw = n.sa_sh;
                  ev[E1FS_IRQ_SMF] = 1'b1;
                end
                ev[E1FS_IRQ_MF] = q.mf_num == E1FS_MF_LAST;
                // [R18] [R14] wrong alignment sequence
                if (q.mf_num == E1FS_MF_ALIGN && n.si6 != E1FS_CRC_MFAS) begin
                  ev[E1FS_IRQ_CMFERR] = 1'b1;
                end
                // [R15] far end block error bits
                if (q.mf_num == E1FS_MF_E1) begin
                  n.e_bit1 = nsh[7];
                end
                if (q.mf_num == E1FS_MF_LAST) begin
                  n.e_bit2 = nsh[7];
                end
              end else if (crc_search && n.si6 == E1FS_CRC_MFAS) begin
                // [R17] second pattern a whole number of multiframes later
                n.fr_since = 7'h00;
                n.have_prev = 1'b1;
                if (q.have_prev && fs_inc[3:0] == 4'h0) begin
                  n.crc_al = 1'b1;
                  n.mf_num = E1FS_MF_AFTER_ALIGN;
                end
              end
            end
          end
          // [R21] [R22] [R23] signaling multiframe at end of timeslot 16
          if (q.cnt == E1FS_TS16_END && q.ctrl[E1FS_CTL_CAS_EN]) begin
            n.prev_nib = nsh[7:4];
            n.cas_num = 4'(q.cas_num + 4'h1);
            if (!q.cas_al) begin
              if (nsh[7:4] == 4'h0 && q.prev_nib != 4'h0) begin
                n.cas_al = 1'b1;
                n.cas_num = 4'h0;
              end
            end else if (n.cas_num == 4'h0 && nsh[7:4] != 4'h0) begin
              n.cas_al = 1'b0;
            end
            if (n.cas_al && n.cas_num == 4'h0) begin
              n.extra = {nsh[3], nsh[1], nsh[0]};
              rmf_smp = 1'b1;
              rmf_val = nsh[2];
              ev[E1FS_IRQ_CASMF] = 1'b1;
            end
          end
        end
        default: n.frm = E1FS_HUNT;
      endcase
    end

    // [R16] [R19] [R20] multiframe timers count core clocks while searching
    if (crc_search) begin
      n.t400 = (q.t400 == CRC400_CYCLES) ? q.t400 : q.t400 + 32'h1;
      if (q.t400 == CRC400_CYCLES - 32'h1) begin
        n.iw = 1'b1;
      end
      n.t8 = q.t8 + 32'h1;
      if (q.t8 == CRC8_CYCLES - 32'h1) begin
        // window lost: offline search flagged, a fresh 8 ms check begins
        n.t8 = 32'h0;
        n.offline = 1'b1;
        n.have_prev = 1'b0;
      end
    end
    if (n.crc_al) begin
      n.offline = 1'b0;
      n.t8 = 32'h0;
    end

    // [R7] red alarm after continuous out of frame
    if (q.frm != E1FS_SYNC) begin
      n.red_cnt = q.red ? q.red_cnt : q.red_cnt + 32'h1;
      if (q.red_cnt == RED_CYCLES - 32'h1) begin
        n.red = 1'b1;
      end
    end else begin
      n.red_cnt = 32'h0;
      n.red = 1'b0;
    end

    // [R1] [R9] [R25] reframe or unframed mode restart the search
    if (reframe || n.ctrl[E1FS_CTL_UNFRAMED]) begin
      n.frm = E1FS_HUNT;
      n.ts16_valid = 1'b0;
    end
    // [R11] losing the frame drops every higher alignment
    if (n.frm != E1FS_SYNC) begin
      n.crc_al = 1'b0;
      n.cas_al = 1'b0;
      n.have_prev = 1'b0;
      n.offline = 1'b0;
      n.iw = 1'b0;
      n.t8 = 32'h0;
      n.t400 = 32'h0;
    end
    if (!n.ctrl[E1FS_CTL_CAS_EN]) begin
      n.cas_al = 1'b0;
    end
    if (!n.ctrl[E1FS_CTL_CRC_EN]) begin
      n.crc_al = 1'b0;
    end

    // [R26] status changes raise indications
    ev[E1FS_IRQ_OOF] = (n.frm == E1FS_SYNC) != (q.frm == E1FS_SYNC);
    ev[E1FS_IRQ_OOCMF] = n.crc_al != q.crc_al;
    ev[E1FS_IRQ_OOSMF] = n.cas_al != q.cas_al;
    // [R26] a new event wins over a clear in the same cycle
    n.ind = (q.ind & ~clr) | ev;
    // [R8] interrupt output gated by enables
    n.irq = |(n.ind & n.en);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.frm <= E1FS_HUNT;
      q.ctrl <= E1FS_CTRL_RST;
      q.en <= E1FS_EN_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rd_data;
  assign irq = q.irq;
  assign ts16_data = q.ts16_data;
  assign ts16_valid = q.ts16_valid;
  assign bypass_data = q.byp_data;
  assign bypass_valid = q.byp_valid;

endmodule

// ---- dv/e1fs_line_src.sv ----
// far-end line source: framed pcm with crc-4 and signaling multiframes
module e1fs_line_src (
  input wire logic core_clk,
  input wire logic run,
  input wire logic bad_fas,
  output logic rx_line_clk,
  output logic rx_line_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // si per frame: crc bits 0, alignment 001011 in odd frames 1..11, e bits 1
  localparam logic [15:0] SI_SEQ = 16'hAA20;
  int unsigned ph = 0;
  int unsigned bitn = 0;
  int unsigned frm = 0;
  logic [7:0] cur;
  function automatic logic [7:0] octet(int unsigned f, int unsigned ts, logic bad);
    if (ts == 0 && f % 2 == 0) return {SI_SEQ[f], bad ? 7'h7F : 7'h1B};
    if (ts == 0) return {SI_SEQ[f], 2'b11, 5'h16};
    if (ts == 16) return (f == 0) ? 8'h0B : 8'h5A;
    return 8'hD5;
  endfunction
  initial begin
    rx_line_clk = 1'b0;
    rx_line_data = 1'b0;
  end
  // clock stands still between runs and the data line wanders
  always @(posedge core_clk) begin
    if (!run) begin
      rx_line_clk <= 1'b0;
      rx_line_data <= ~rx_line_data;
    end else begin
      rx_line_clk <= ph >= 3;
      ph <= (ph == 5) ? 0 : ph + 1;
      if (ph == 0) begin
        cur = octet(frm, bitn / 8, bad_fas);
        rx_line_data <= cur[7 - bitn % 8];
        bitn <= (bitn == 255) ? 0 : bitn + 1;
        if (bitn == 255) frm <= (frm + 1) % 16;
      end
    end
  end
endmodule

// ---- dv/e1fs_top_asserts.sv ----
// port assertions of the receive frame synchroniser
module e1fs_top_asserts
  import e1fs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic ts16_data,
  input wire logic ts16_valid,
  input wire logic bypass_data,
  input wire logic bypass_valid
);
  logic [7:0] ctrl_q;
  logic [9:0] gap_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // gap saturates so that a resync at any position stays legal
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 8'h00;
      gap_q <= 10'h3FF;
    end else begin
      if (reg_wr && reg_addr == E1FS_OFS_CTRL) ctrl_q <= reg_wdata;
      if (ts16_valid) gap_q <= 10'h000;
      else if (bypass_valid && gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
    end
  end
  sequence s_stat_rd;
    reg_rd && reg_addr == E1FS_OFS_STATUS;
  endsequence
  sequence s_manual_reframe_wr;
    reg_wr && reg_addr == E1FS_OFS_CTRL && reg_wdata[4] && !ctrl_q[4];
  endsequence
  sequence s_srst_wr;
    reg_wr && reg_addr == E1FS_OFS_CTRL && reg_wdata[E1FS_CTL_SRST];
  endsequence
  chk_srst_hunt: assert property (s_srst_wr ##2 s_stat_rd |=> reg_rdata[0])
    else $error("framer kept lock after soft reset");
  chk_manual_reframe_hunt: assert property (s_manual_reframe_wr ##2 s_stat_rd |=> reg_rdata[0])
    else $error("framer kept lock after manual reframe");
  chk_ts16_bit: assert property (ts16_valid |-> bypass_valid && ts16_data == bypass_data)
    else $error("timeslot 16 bit not the line bit");
  chk_ts16_gap: assert property (ts16_valid |-> gap_q == 10'h000 || gap_q == 10'h0F8
    || gap_q >= 10'h1F4) else $error("timeslot 16 bit off position");
  chk_unfr_quiet: assert property (ctrl_q[0] && $past(ctrl_q[0], 8) |-> !ts16_valid)
    else $error("timeslot 16 output in unframed mode");
  chk_bit_pulse: assert property (bypass_valid |=> !bypass_valid)
    else $error("line bit pulse too long");
  chk_bit_hold: assert property (!bypass_valid |-> $stable(bypass_data))
    else $error("passed bit changed between pulses");
  chk_irq_gate: assert property (reg_wr && reg_addr == E1FS_OFS_EN && reg_wdata == 8'h00
    |-> ##2 !irq) else $error("irq with all enables off");
endmodule
bind e1fs_top e1fs_top_asserts chk_u (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .ts16_data(ts16_data), .ts16_valid(ts16_valid),
  .bypass_data(bypass_data), .bypass_valid(bypass_valid));

// ---- dv/e1fs_top_tb.sv ----
// self-checking bench of the receive frame synchroniser
module e1fs_top_tb import e1fs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic bad_fas = 1'b0;
  logic rx_line_clk;
  logic rx_line_data;
  logic [7:0] reg_rdata;
  logic [7:0] got;
  logic irq;
  logic ts16_data;
  logic ts16_valid;
  logic bypass_data;
  logic bypass_valid;
  int err_count = 0;
  int cmp_count = 0;
  always #2 core_clk = ~core_clk;
  e1fs_line_src src_u (.core_clk(core_clk), .run(run), .bad_fas(bad_fas),
    .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data));
  e1fs_top #(.CRC8_CYCLES(60000), .CRC400_CYCLES(200000), .RED_CYCLES(5000)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .rx_line_data(rx_line_data),
    .rx_line_clk(rx_line_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .ts16_data(ts16_data), .ts16_valid(ts16_valid), .bypass_data(bypass_data),
    .bypass_valid(bypass_valid));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, string n);
    rd(a);
    chk(n, got & m, e);
  endtask
  task automatic poll(input int b, input logic v, input int lim);
    int k;
    k = 0;
    rd(E1FS_OFS_STATUS);
    while (got[b] !== v && k < lim) begin
      rd(E1FS_OFS_STATUS);
      k++;
    end
  endtask
  task automatic t_regs();
    rdm(E1FS_OFS_CTRL, 8'hFF, E1FS_CTRL_RST, "ctrl reset");
    rdm(E1FS_OFS_EN, 8'hFF, E1FS_EN_RST, "enable reset");
    wr(E1FS_OFS_STATUS, 8'h00);
    rdm(E1FS_OFS_STATUS, 8'h07, 8'h07, "status reset");
    rdm(4'hD, 8'hFF, 8'h00, "unmapped");
  endtask
  task automatic t_align();
    wr(E1FS_OFS_CTRL, 8'h06);
    run <= 1'b1;
    poll(0, 1'b0, 4000);
    rdm(E1FS_OFS_STATUS, 8'h01, 8'h00, "frame lock");
    // signaling frame zero comes round only once in sixteen frames
    poll(2, 1'b0, 16000);
    rdm(E1FS_OFS_STATUS, 8'h04, 8'h00, "signaling lock");
    poll(1, 1'b0, 30000);
    rdm(E1FS_OFS_STATUS, 8'hFA, 8'h80, "crc lock");
    // lock lands at frame 11: frames 13 and 15 must pass before the words are read
    repeat (7000) @(posedge core_clk);
    rdm(E1FS_OFS_NAT, 8'h1F, 8'h16, "national");
    rdm(E1FS_OFS_INTL, 8'h05, 8'h04, "international");
    rdm(E1FS_OFS_EXTRA, 8'h07, 8'h07, "extra");
    rdm(E1FS_OFS_SA4, 8'h0F, 8'h0F, "sa4 word");
    rdm(E1FS_OFS_SA8, 8'h0F, 8'h00, "sa8 word");
    rdm(E1FS_OFS_CRC, 8'h7F, 8'h30, "crc and e bits");
  endtask
  task automatic t_events();
    rdm(E1FS_OFS_IND, 8'hF8, 8'hF0, "boundary events");
    wr(E1FS_OFS_IND, 8'hFF);
    wr(E1FS_OFS_EN, 8'h10);
    repeat (3000) @(posedge core_clk);
    #1 chk("irq on", {7'h00, irq}, 8'h01);
    wr(E1FS_OFS_EN, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk("irq off", {7'h00, irq}, 8'h00);
    wr(E1FS_OFS_IND, 8'h10);
    rdm(E1FS_OFS_IND, 8'h10, 8'h00, "clear by one");
  endtask
  task automatic t_unframed();
    int n;
    n = 0;
    wr(E1FS_OFS_CTRL, 8'h07);
    poll(0, 1'b1, 50);
    rdm(E1FS_OFS_STATUS, 8'h01, 8'h01, "unframed hunt");
    repeat (96) begin
      @(posedge core_clk);
      #1 n += bypass_valid;
    end
    chk("bypass bits", 8'(n), 8'h10);
    wr(E1FS_OFS_CTRL, 8'h06);
    poll(0, 1'b0, 4000);
  endtask
  task automatic t_reframe();
    wr(E1FS_OFS_CTRL, 8'h16);
    rdm(E1FS_OFS_STATUS, 8'h01, 8'h01, "manual reframe");
    poll(0, 1'b0, 4000);
    wr(E1FS_OFS_CTRL, 8'h46);
    rdm(E1FS_OFS_STATUS, 8'h01, 8'h01, "soft reset");
    poll(0, 1'b0, 4000);
    rdm(E1FS_OFS_STATUS, 8'h01, 8'h00, "relock");
  endtask
  task automatic t_red();
    bad_fas <= 1'b1;
    // three bad alignment words take up to six frames
    poll(0, 1'b1, 8000);
    rdm(E1FS_OFS_STATUS, 8'h61, 8'h01, "early red");
    poll(6, 1'b1, 4000);
    rdm(E1FS_OFS_STATUS, 8'h40, 8'h40, "red alarm");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_align();
    t_events();
    t_unframed();
    t_reframe();
    t_red();
    final_report();
  end
  // about 82k cycles of traffic expected, so 150k cycles means a hang
  initial begin
    #600000;
    err_count++;
    final_report();
  end
endmodule
